// >>> rtl/scn_pkg.sv
// package: constants, register map and types of the supply class sequencer
package scn_pkg;
   // timing
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
   localparam int unsigned ATR_WAIT_US  = 20_000;
   localparam int unsigned ATR_WAIT_CYC = ATR_WAIT_US * CLK_PER_US;
   localparam int unsigned DEACT_US     = 10;
   localparam int unsigned DEACT_CYC    = DEACT_US * CLK_PER_US;
   localparam logic [1:0]  RETRY_MAX    = 2'h3;

   // register byte addresses
   localparam logic [4:0] ADDR_CTRL   = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_ATR    = 5'h08;
   localparam logic [4:0] ADDR_FDWANT = 5'h0c;
   localparam logic [4:0] ADDR_APPPWR = 5'h10;
   localparam logic [4:0] ADDR_ISTAT  = 5'h14;
   localparam logic [4:0] ADDR_IMASK  = 5'h18;

   // control fields and reset values
   localparam int unsigned CTRL_START     = 0;
   localparam int unsigned CTRL_EXTRA     = 1;
   localparam int unsigned CTRL_AVAIL_LSB = 4;
   localparam logic [2:0]  AVAIL_RST      = 3'h7;
   localparam logic [7:0]  FDWANT_RST     = 8'h11;
   localparam logic [7:0]  APPPWR_RST     = 8'h00;

   // interrupt status bits
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_REJ  = 1;
   localparam int unsigned IRQ_SW   = 2;
   localparam int unsigned IRQ_PPS  = 3;
   localparam int unsigned IRQ_W    = 4;

   // answer-to-reset content
   localparam logic [7:0] TS_DIRECT  = 8'h3b;
   localparam logic [7:0] TS_INVERSE = 8'h3f;
   localparam logic [7:0] HIST_CAT   = 8'h80;
   localparam logic [7:0] TAG_DATA   = 8'h31;
   localparam logic [7:0] TAG_CAPS   = 8'h73;
   localparam logic [3:0] PROT_GLOB  = 4'hf;
   localparam logic [7:0] FD_DEF     = 8'h11;
   localparam logic [7:0] FD_512_8   = 8'h94;
   localparam logic [7:0] FD_512_16  = 8'h95;
   localparam logic [2:0] CLS_ONLY_A = 3'h1;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
      logic       err;
   } scn_lnk_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_ACT = 3'b001, S_DEACT = 3'b010, S_DONE = 3'b011, S_REJ = 3'b100
   } scn_sst_t;

   typedef enum logic [2:0] {
      P_TS = 3'b000, P_T0 = 3'b001, P_IF = 3'b010, P_HIST = 3'b011, P_TCK = 3'b100,
      P_END = 3'b101
   } scn_pst_t;
endpackage

// >>> rtl/scn_sequencer.sv
// supply class sequencer with answer-to-reset checker and avalon-mm registers
// Function
// - start at lowest available supply class
// - no answer: deactivate, retry next higher class
// - unsupported class: reactivate at card's class
// - corrupted answer: three tries same class
// - then optionally one retry, next higher only
// - application power from select or status response
// - accept foreign protocols, historical and check bytes
// - support 512/8, 512/16 and 372/1 factors
// - factors other than 372/1 need a PPS exchange
`timescale 1ns/1ps
module scn_sequencer #(
   parameter int unsigned ATR_WAIT_CYC = scn_pkg::ATR_WAIT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        lnk_clk_i,
   input  wire logic [7:0]  lnk_data_i,
   input  wire logic        lnk_last_i,
   input  wire logic        lnk_err_i,
   output logic             card_act_o,
   output logic      [2:0]  vcc_class_o,
   output logic             pps_req_o,
   output logic      [7:0]  fd_req_o,
   output logic      [7:0]  app_pwr_o,
   output logic             irq_o
);
   function automatic logic [2:0] lowest(input logic [2:0] av);
      logic [2:0] r;
      r = '0;
      for (int j = 0; j < 3; j++) if (av[j]) r = 3'(1 << j);
      return r;
   endfunction

   function automatic logic [2:0] next_up(input logic [2:0] cur, input logic [2:0] av);
      logic [2:0] r;
      r = '0;
      for (int j = 0; j < 3; j++) if (av[j] && (3'(1 << j) < cur)) r = 3'(1 << j);
      return r;
   endfunction

   function automatic logic is_mand(input logic [7:0] fd);
      return (fd == scn_pkg::FD_DEF) || (fd == scn_pkg::FD_512_8) || (fd == scn_pkg::FD_512_16);
   endfunction

   // link synchroniser; data must be stable a cycle either side of the link edge
   scn_pkg::scn_lnk_t s1_q, s2_q;
   logic              lc1_q, lc2_q, lc3_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q  <= '0;
         s2_q  <= '0;
         lc1_q <= 1'b0;
         lc2_q <= 1'b0;
         lc3_q <= 1'b0;
      end else begin
         s1_q  <= '{data: lnk_data_i, last: lnk_last_i, err: lnk_err_i};
         s2_q  <= s1_q;
         lc1_q <= lnk_clk_i;
         lc2_q <= lc1_q;
         lc3_q <= lc2_q;
      end
   end
   logic lv;
   assign lv = lc2_q & ~lc3_q;

   // ---------------- register bus and interrupt state ----------------
   logic        wait_q, wait_d, go_q, go_d, extra_en_q, extra_en_d, irq_q, irq_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0]  avail_q, avail_d;
   logic [7:0]  fdw_q, fdw_d, pwr_q, pwr_d;
   localparam int unsigned IRQ_W_L = scn_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] istat_q, istat_d, imask_q, imask_d;
   // sequencer and parser state, declared here for the read mux
   scn_pkg::scn_sst_t st_q, st_d;
   scn_pkg::scn_pst_t ps_q, ps_d;
   logic [2:0]  cls_q, cls_d, pend_q, pend_d;
   logic [1:0]  retry_q, retry_d;
   logic        extra_q, extra_d, nm_q, nm_d;
   logic [4:0]  ccls_q, ccls_d;
   logic        clsv_q, clsv_d, t15_q, t15_d;
   logic [7:0]  ta1_q, ta1_d;
   logic        done_ev, rej_ev, sw_ev, pps_q, pps_d;
   logic        wr;

   always_comb begin
      wait_d     = 1'b1;
      rdata_d    = rdata_q;
      go_d       = 1'b0;
      avail_d    = avail_q;
      extra_en_d = extra_en_q;
      fdw_d      = fdw_q;
      pwr_d      = pwr_q;
      imask_d    = imask_q;
      istat_d    = istat_q;
      wr         = avs_write_i && !wait_q && avs_byteenable_i[0];
      if ((avs_read_i || avs_write_i) && wait_q) begin
         wait_d = 1'b0;
         rdata_d = '0;
         if (avs_read_i) begin
            unique case (avs_address_i)
               scn_pkg::ADDR_CTRL:   rdata_d = 32'({avail_q, 2'b00, extra_en_q, 1'b0});
               scn_pkg::ADDR_STATUS: rdata_d = 32'({nm_q, extra_q, retry_q, 1'b0, cls_q,
                                                    1'b0, st_q});
               scn_pkg::ADDR_ATR:    rdata_d = 32'({ta1_q, 1'b0, t15_q, clsv_q, ccls_q});
               scn_pkg::ADDR_FDWANT: rdata_d = 32'(fdw_q);
               scn_pkg::ADDR_APPPWR: rdata_d = 32'(pwr_q);
               scn_pkg::ADDR_ISTAT:  rdata_d = 32'(istat_q);
               scn_pkg::ADDR_IMASK:  rdata_d = 32'(imask_q);
               default:              rdata_d = '0;
            endcase
         end
      end
      if (wr) begin
         unique case (avs_address_i)
            scn_pkg::ADDR_CTRL: begin
               go_d       = avs_writedata_i[scn_pkg::CTRL_START];
               extra_en_d = avs_writedata_i[scn_pkg::CTRL_EXTRA];
               avail_d    = avs_writedata_i[scn_pkg::CTRL_AVAIL_LSB +: 3];
            end
            scn_pkg::ADDR_FDWANT: fdw_d = avs_writedata_i[7:0];
            scn_pkg::ADDR_APPPWR: pwr_d = avs_writedata_i[7:0];
            scn_pkg::ADDR_ISTAT:  istat_d = istat_q & ~avs_writedata_i[IRQ_W_L-1:0];
            scn_pkg::ADDR_IMASK:  imask_d = avs_writedata_i[IRQ_W_L-1:0];
            default: ;
         endcase
      end
      // a new event beats a simultaneous write-one-to-clear
      if (done_ev) istat_d[scn_pkg::IRQ_DONE] = 1'b1;
      if (rej_ev)  istat_d[scn_pkg::IRQ_REJ]  = 1'b1;
      if (sw_ev)   istat_d[scn_pkg::IRQ_SW]   = 1'b1;
      if (pps_q)   istat_d[scn_pkg::IRQ_PPS]  = 1'b1;
      irq_d = |(istat_q & imask_q);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q     <= 1'b1;
         rdata_q    <= '0;
         go_q       <= 1'b0;
         avail_q    <= scn_pkg::AVAIL_RST;
         extra_en_q <= 1'b0;
         fdw_q      <= scn_pkg::FDWANT_RST;
         pwr_q      <= scn_pkg::APPPWR_RST;
         istat_q    <= '0;
         imask_q    <= '0;
         irq_q      <= 1'b0;
      end else begin
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         go_q       <= go_d;
         avail_q    <= avail_d;
         extra_en_q <= extra_en_d;
         fdw_q      <= fdw_d;
         pwr_q      <= pwr_d;
         istat_q    <= istat_d;
         imask_q    <= imask_d;
         irq_q      <= irq_d;
      end
   end

   // ---------------- answer-to-reset parser ----------------
   logic [3:0] y_q, y_d, grp_q, grp_d, hl_q, hl_d, hp_q, hp_d;
   logic [7:0] x_q, x_d;
   logic [2:0] hchk_q, hchk_d;
   logic       t15n_q, t15n_d, tck_q, tck_d, tsok_q, tsok_d, err_q, err_d, ovf_q, ovf_d;
   logic       done_q, done_d, bad_q, bad_d;

   always_comb begin
      ps_d = ps_q;   y_d = y_q;     grp_d = grp_q;   t15n_d = t15n_q; hl_d = hl_q;
      hp_d = hp_q;   tck_d = tck_q; x_d = x_q;       tsok_d = tsok_q; t15_d = t15_q;
      hchk_d = hchk_q; ccls_d = ccls_q; clsv_d = clsv_q; ta1_d = ta1_q;
      err_d = err_q; ovf_d = ovf_q; done_d = 1'b0;   bad_d = bad_q;
      if (st_q != scn_pkg::S_ACT) begin
         ps_d = scn_pkg::P_TS; y_d = '0; grp_d = '0; t15n_d = 1'b0; hl_d = '0; hp_d = '0;
         tck_d = 1'b0; x_d = '0; tsok_d = 1'b0; hchk_d = '0; err_d = 1'b0; ovf_d = 1'b0;
         bad_d = 1'b0;
      end else if (lv) begin
         err_d = err_q | s2_q.err;
         if (ps_q != scn_pkg::P_TS) x_d = x_q ^ s2_q.data;
         unique case (ps_q)
            scn_pkg::P_TS: begin
               tsok_d = (s2_q.data == scn_pkg::TS_DIRECT) || (s2_q.data == scn_pkg::TS_INVERSE);
               ccls_d = '0;
               clsv_d = 1'b0;
               ta1_d  = scn_pkg::FD_DEF;
               t15_d  = 1'b0;
               ps_d   = scn_pkg::P_T0;
            end
            scn_pkg::P_T0: begin
               y_d   = s2_q.data[7:4];
               hl_d  = s2_q.data[3:0];
               grp_d = 4'h1;
               ps_d  = scn_pkg::P_IF;
            end
            scn_pkg::P_IF: begin
               if (y_q[0]) begin
                  y_d[0] = 1'b0;
                  if (grp_q == 4'h1) ta1_d = s2_q.data;
                  if (grp_q > 4'h2 && t15n_q) begin
                     ccls_d = s2_q.data[4:0];
                     clsv_d = 1'b1;
                  end
               end else if (y_q[1]) begin
                  y_d[1] = 1'b0;
               end else if (y_q[2]) begin
                  y_d[2] = 1'b0;
               end else begin
                  // any protocol number is walked through, not just 0 and 1
                  y_d    = s2_q.data[7:4];
                  grp_d  = grp_q + 4'h1;
                  t15n_d = s2_q.data[3:0] == scn_pkg::PROT_GLOB;
                  if (s2_q.data[3:0] != 4'h0) tck_d = 1'b1;
                  if (s2_q.data[3:0] == scn_pkg::PROT_GLOB) t15_d = 1'b1;
               end
            end
            scn_pkg::P_HIST: begin
               hp_d = hp_q + 4'h1;
               hl_d = hl_q - 4'h1;
               if (hp_q == 4'h0 && s2_q.data == scn_pkg::HIST_CAT) hchk_d[0] = 1'b1;
               if (hp_q == 4'h1 && s2_q.data == scn_pkg::TAG_DATA) hchk_d[1] = 1'b1;
               if (hp_q == 4'h3 && s2_q.data == scn_pkg::TAG_CAPS) hchk_d[2] = 1'b1;
               if (hl_q == 4'h1) ps_d = tck_q ? scn_pkg::P_TCK : scn_pkg::P_END;
            end
            scn_pkg::P_TCK: ps_d = scn_pkg::P_END;
            scn_pkg::P_END: ovf_d = 1'b1;
            default:        ps_d = scn_pkg::P_END;
         endcase
         if (ps_d == scn_pkg::P_IF && y_d == 4'h0) begin
            ps_d = (hl_d != 4'h0) ? scn_pkg::P_HIST :
                   (tck_d ? scn_pkg::P_TCK : scn_pkg::P_END);
         end
         if (s2_q.last) begin
            done_d = 1'b1;
            bad_d  = err_d || ovf_d || ps_d != scn_pkg::P_END || !tsok_d || !t15_d ||
                     hchk_d != 3'h7 || (tck_d && x_d != 8'h00);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ps_q <= scn_pkg::P_TS; y_q <= '0; grp_q <= '0; t15n_q <= 1'b0; hl_q <= '0;
         hp_q <= '0; tck_q <= 1'b0; x_q <= '0; tsok_q <= 1'b0; t15_q <= 1'b0;
         hchk_q <= '0; ccls_q <= '0; clsv_q <= 1'b0; ta1_q <= scn_pkg::FD_DEF;
         err_q <= 1'b0; ovf_q <= 1'b0; done_q <= 1'b0; bad_q <= 1'b0;
      end else begin
         ps_q <= ps_d; y_q <= y_d; grp_q <= grp_d; t15n_q <= t15n_d; hl_q <= hl_d;
         hp_q <= hp_d; tck_q <= tck_d; x_q <= x_d; tsok_q <= tsok_d; t15_q <= t15_d;
         hchk_q <= hchk_d; ccls_q <= ccls_d; clsv_q <= clsv_d; ta1_q <= ta1_d;
         err_q <= err_d; ovf_q <= ovf_d; done_q <= done_d; bad_q <= bad_d;
      end
   end

   // ---------------- activation sequencer ----------------
   logic [31:0] tmr_q, tmr_d;
   logic        act_q, act_d, sw, rej, rej_q, sw_q;
   logic [2:0]  nc, lo_w, nu_w, cc_w, pick_w;
   assign lo_w   = lowest(avail_q);
   assign nu_w   = next_up(cls_q, avail_q);
   // no class field at all: treat as a class A only card
   assign cc_w   = clsv_q ? ccls_q[2:0] : scn_pkg::CLS_ONLY_A;
   assign pick_w = lowest(cc_w & avail_q);

   always_comb begin
      st_d = st_q; cls_d = cls_q; pend_d = pend_q; retry_d = retry_q; extra_d = extra_q;
      nm_d = nm_q; tmr_d = tmr_q + 32'h1; pps_d = 1'b0; done_ev = 1'b0;
      sw = 1'b0; rej = 1'b0; nc = nu_w;
      unique case (st_q)
         scn_pkg::S_ACT: begin
            if (done_q && !bad_q) begin
               if ((cc_w & cls_q) != 3'h0) begin
                  st_d = scn_pkg::S_DONE;
                  done_ev = 1'b1;
                  nm_d  = !is_mand(fdw_q);
                  pps_d = fdw_q != scn_pkg::FD_DEF;
               end else if (pick_w != 3'h0) begin
                  sw = 1'b1;
                  nc = pick_w;
               end else begin
                  rej = 1'b1;
               end
            end else if (done_q || tmr_q == 32'(ATR_WAIT_CYC - 1)) begin
               if (!done_q && ps_q == scn_pkg::P_TS) begin
                  if (nu_w != 3'h0) sw = 1'b1;
                  else rej = 1'b1;
               end else if (retry_q + 2'h1 < scn_pkg::RETRY_MAX && !extra_q) begin
                  retry_d = retry_q + 2'h1;
                  pend_d  = cls_q;
                  st_d    = scn_pkg::S_DEACT;
                  tmr_d   = '0;
               end else if (extra_en_q && !extra_q && nu_w != 3'h0) begin
                  sw = 1'b1;
                  extra_d = 1'b1;
               end else begin
                  rej = 1'b1;
               end
            end
         end
         scn_pkg::S_DEACT: begin
            if (tmr_q == 32'(scn_pkg::DEACT_CYC - 1)) begin
               cls_d = pend_q;
               st_d  = scn_pkg::S_ACT;
               tmr_d = '0;
            end
         end
         default: begin
            tmr_d = '0;
            if (go_q) begin
               retry_d = '0;
               extra_d = 1'b0;
               nm_d    = 1'b0;
               cls_d   = lo_w;
               st_d    = (lo_w != 3'h0) ? scn_pkg::S_ACT : scn_pkg::S_REJ;
               rej     = lo_w == 3'h0;
            end
         end
      endcase
      if (sw) begin
         pend_d  = nc;
         retry_d = '0;
         st_d    = scn_pkg::S_DEACT;
         tmr_d   = '0;
      end
      if (rej) st_d = scn_pkg::S_REJ;
      act_d = st_d == scn_pkg::S_ACT;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= scn_pkg::S_IDLE; cls_q <= '0; pend_q <= '0; retry_q <= '0;
         extra_q <= 1'b0; nm_q <= 1'b0; tmr_q <= '0; pps_q <= 1'b0; act_q <= 1'b0;
         rej_q <= 1'b0; sw_q <= 1'b0;
      end else begin
         st_q <= st_d; cls_q <= cls_d; pend_q <= pend_d; retry_q <= retry_d;
         extra_q <= extra_d; nm_q <= nm_d; tmr_q <= tmr_d; pps_q <= pps_d; act_q <= act_d;
         rej_q <= rej; sw_q <= sw;
      end
   end
   assign rej_ev = rej_q;
   assign sw_ev  = sw_q;

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign card_act_o        = act_q;
   assign vcc_class_o       = cls_q;
   assign pps_req_o         = pps_q;
   assign fd_req_o          = fdw_q;
   assign app_pwr_o         = pwr_q;
   assign irq_o             = irq_q;

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_atr_end;
      st_q == scn_pkg::S_ACT && done_q;
   endsequence
   sequence s_corrupt;
      s_atr_end ##0 bad_q;
   endsequence
   sequence s_silent;
      st_q == scn_pkg::S_ACT && !done_q && tmr_q == 32'(ATR_WAIT_CYC - 1) && ps_q == scn_pkg::P_TS;
   endsequence

   first_class_a: assert property (
      (st_q != scn_pkg::S_ACT && st_q != scn_pkg::S_DEACT && go_q && lo_w != 3'h0)
      |=> st_q == scn_pkg::S_ACT && cls_q == $past(lo_w)) else $error("wrong first class");
   no_atr_step_a: assert property (
      s_silent ##0 nu_w != 3'h0 |=> st_q == scn_pkg::S_DEACT && pend_q == $past(nu_w))
      else $error("no step up after silence");
   class_move_a: assert property (
      s_atr_end ##0 !bad_q && (cc_w & cls_q) == 3'h0 && pick_w != 3'h0
      |=> st_q == scn_pkg::S_DEACT && pend_q == $past(pick_w)) else $error("bad class move");
   same_class_a: assert property (
      s_corrupt ##0 retry_q < 2'h2 && !extra_q
      |=> st_q == scn_pkg::S_DEACT && pend_q == cls_q && retry_q == $past(retry_q) + 2'h1)
      else $error("corrupt retry not at same class");
   extra_up_a: assert property (
      s_corrupt ##0 retry_q == 2'h2 && extra_en_q && !extra_q && nu_w != 3'h0
      |=> extra_q && pend_q == $past(nu_w) && retry_q == 2'h0) else $error("bad extra retry");
   reject_flag_a: assert property (
      s_corrupt ##0 (retry_q == 2'h2 || extra_q) && !(extra_en_q && !extra_q && nu_w != 3'h0)
      |=> st_q == scn_pkg::S_REJ ##1 istat_q[scn_pkg::IRQ_REJ]) else $error("no rejection");
   retry_clear_a: assert property (
      st_q == scn_pkg::S_DEACT && pend_q != cls_q |-> retry_q == 2'h0)
      else $error("retries kept over class change");
   pps_start_a: assert property (
      s_atr_end ##0 !bad_q && (cc_w & cls_q) != 3'h0 && fdw_q != scn_pkg::FD_DEF
      |=> pps_q ##1 !pps_q) else $error("pps request missing");
   global_seen_a: assert property (
      done_q && !t15_q |-> bad_q) else $error("answer without global group accepted");
   hist_layout_a: assert property (
      done_q && hchk_q != 3'h7 |-> bad_q) else $error("bad historical layout accepted");
   irq_level_a: assert property (
      ##1 irq_q == $past(|(istat_q & imask_q))) else $error("irq level wrong");
endmodule

// >>> verification/scn_card_model.sv
// behavioural smart_card answering reset over the character strobe link
`timescale 1ns/1ps
module scn_card_model (
   output logic       lnk_clk_o,
   output logic [7:0] lnk_data_o,
   output logic       lnk_last_o,
   output logic       lnk_err_o
);
   logic [7:0] atr [12];
   initial begin
      lnk_clk_o  = 1'b0;
      lnk_data_o = 8'h00;
      lnk_last_o = 1'b0;
      lnk_err_o  = 1'b0;
   end
   // ta3 carries the classes; td1 names a foreign protocol, td2 the global set
   // bad: 1 reception error, 2 no global group, 3 wrong category byte
   task automatic send(input logic [2:0] cls, input logic [1:0] bad);
      logic [7:0] tck;
      tck = 8'h00;
      atr = '{8'h3b, 8'h95, 8'h94, 8'h85,
              (bad == 2'h2) ? 8'h10 : 8'h1f, {5'h0, cls},
              (bad == 2'h3) ? 8'h81 : 8'h80, 8'h31,
              8'ha0, 8'h73, 8'h21, 8'h00};
      for (int i = 1; i < 11; i++) tck ^= atr[i];
      atr[11] = tck;
      for (int i = 0; i < 12; i++) begin
         lnk_data_o = atr[i];
         lnk_last_o = (i == 11);
         lnk_err_o  = (bad == 2'h1) && (i == 6);
         #80 lnk_clk_o = 1'b1;
         #80 lnk_clk_o = 1'b0;
      end
      // released line shows the inverse so stale data never looks valid
      lnk_data_o = ~lnk_data_o;
      lnk_last_o = 1'b0;
      lnk_err_o  = 1'b0;
   endtask
endmodule

// >>> verification/tb_scn_sequencer.sv
// self-checking bench of the supply class sequencer
`timescale 1ns/1ps
module tb_scn_sequencer;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [4:0]  avs_address_i = 5'h00;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, q;
   logic        avs_waitrequest_o, lnk_clk, lnk_last, lnk_err, card_act_o, pps_req_o, irq_o;
   logic [7:0]  lnk_data, fd_req_o, app_pwr_o;
   logic [2:0]  vcc_class_o;
   int          n_fail = 0;
   int          num_checks = 0;
   int          n_pps = 0;
   // available, card classes, first class, final class
   logic [2:0]  rows [4][4] = '{'{3'h7, 3'h4, 3'h4, 3'h4}, '{3'h7, 3'h3, 3'h4, 3'h2},
                               '{3'h3, 3'h1, 3'h2, 3'h1}, '{3'h1, 3'h1, 3'h1, 3'h1}};
   logic [4:0]  ra [7] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c};
   logic [31:0] rv [7] = '{32'h70, 32'h0, 32'h11, 32'h0, 32'h0, 32'h0, 32'h0};
   scn_sequencer #(.ATR_WAIT_CYC(200)) i_scn_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .lnk_clk_i(lnk_clk), .lnk_data_i(lnk_data), .lnk_last_i(lnk_last), .lnk_err_i(lnk_err),
      .card_act_o(card_act_o), .vcc_class_o(vcc_class_o), .pps_req_o(pps_req_o),
      .fd_req_o(fd_req_o), .app_pwr_o(app_pwr_o), .irq_o(irq_o));
   scn_card_model i_scn_card_model (.lnk_clk_o(lnk_clk), .lnk_data_o(lnk_data),
      .lnk_last_o(lnk_last), .lnk_err_o(lnk_err));
   // one-cycle pulse, so counted at every edge rather than polled
   always @(posedge clk_i) if (pps_req_o === 1'b1) n_pps <= n_pps + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // request held until the rising edge that sees waitrequest low; data taken there
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      avs_write_i     <= w;
      avs_read_i      <= !w;
      avs_address_i   <= a;
      avs_writedata_i <= d;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      q = avs_readdata_o;
      if (n == 50) begin
         n_fail++;
         summarize();
      end
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      // return where outputs are settled and off the link's sampling edge
      @(negedge clk_i);
   endtask
   task automatic wait_act(input logic v);
      int n;
      for (n = 0; n < 3000 && card_act_o !== v; n++) @(negedge clk_i);
      if (n == 3000) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic wait_st(input logic [2:0] s);
      int n;
      for (n = 0; n < 300; n++) begin
         bus(1'b0, scn_pkg::ADDR_STATUS, 32'h0);
         if (q[2:0] === s) break;
      end
      chk(q[2:0], s, "state");
      if (n == 300) summarize();
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (19) @(posedge clk_i);
      rst_n_i <= 1'b1;
   endtask
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      for (int r = 0; r < 4; r++) begin
         do_reset();
         bus(1'b1, scn_pkg::ADDR_IMASK, 32'h1);
         bus(1'b1, scn_pkg::ADDR_CTRL, {25'h0, rows[r][0], 4'h1});
         wait_act(1'b1);
         chk(vcc_class_o, rows[r][2], "first class");
         i_scn_card_model.send(rows[r][1], 2'h0);
         if (rows[r][3] !== rows[r][2]) begin
            wait_act(1'b0);
            wait_act(1'b1);
            chk(vcc_class_o, rows[r][3], "card class");
            i_scn_card_model.send(rows[r][1], 2'h0);
         end
         wait_st(3'h3);
         bus(1'b0, scn_pkg::ADDR_ATR, 32'h0);
         chk(q, {16'h0, 8'h94, 3'h3, 2'h0, rows[r][1]}, "answer fields");
         chk(irq_o, 1'b1, "irq");
         bus(1'b1, scn_pkg::ADDR_ISTAT, 32'hf);
         bus(1'b0, scn_pkg::ADDR_ISTAT, 32'h0);
         chk(irq_o, 1'b0, "irq cleared");
         $display("row %0d done", r);
      end
      do_reset();
      chk({card_act_o, vcc_class_o, fd_req_o, app_pwr_o}, 20'h01100, "reset outputs");
      avs_byteenable_i <= 4'he;
      bus(1'b1, scn_pkg::ADDR_FDWANT, 32'hff);
      @(posedge clk_i);
      avs_byteenable_i <= 4'hf;
      bus(1'b1, 5'h1c, 32'hffffffff);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk(q, rv[i], "reset register");
      end
      bus(1'b1, scn_pkg::ADDR_APPPWR, 32'h2a);
      chk(app_pwr_o, 8'h2a, "app power");
      $display("reset test done");
      bus(1'b1, scn_pkg::ADDR_FDWANT, 32'h13);
      chk(fd_req_o, 8'h13, "factor request");
      bus(1'b1, scn_pkg::ADDR_CTRL, 32'h31);
      wait_act(1'b1);
      chk(vcc_class_o, 3'h2, "lowest class");
      wait_act(1'b0);
      wait_act(1'b1);
      chk(vcc_class_o, 3'h1, "next higher");
      i_scn_card_model.send(3'h1, 2'h0);
      wait_st(3'h3);
      chk(q[11], 1'b1, "factor outside pairs");
      chk(n_pps, 1, "pps pulses");
      bus(1'b0, scn_pkg::ADDR_ISTAT, 32'h0);
      chk({q[3:0], irq_o}, 5'h1a, "masked events");
      $display("no answer test done");
      do_reset();
      bus(1'b1, scn_pkg::ADDR_CTRL, 32'h72);
      bus(1'b1, scn_pkg::ADDR_CTRL, 32'h73);
      for (int k = 0; k < 4; k++) begin
         wait_act(1'b1);
         chk(vcc_class_o, (k < 3) ? 3'h4 : 3'h2, "retry class");
         if (k == 3) begin
            bus(1'b0, scn_pkg::ADDR_STATUS, 32'h0);
            chk(q[9:8], 2'h0, "retry count");
         end
         i_scn_card_model.send(3'h4, 2'((k % 3) + 1));
         wait_act(1'b0);
      end
      wait_st(3'h4);
      bus(1'b0, scn_pkg::ADDR_ISTAT, 32'h0);
      chk(q[1], 1'b1, "reject event");
      $display("corrupt test done");
      summarize();
   end
endmodule
